/* File: hw/apm_defines.svh */
// constants for the converter power-mode host controller
// How it works
// [R01] hold frame low ten or more falling clock edges to stay fully powered
// [R02] rising frame after edge ten, before sixteen aborts conversion, stays powered
// [R03] host gives sixteen serial clocks per frame for a full conversion
// [R04] between frames the frame line idles high, or low until shortly before next
// [R05] host waits the quiet interval after output release before next frame fall
// [R06] rising frame between edges two and nine enters power-down
// [R07] power-down entry aborts the conversion and releases the result output
// [R08] rising frame before edge two is ignored, mode unchanged
// [R09] dummy frame held past edge ten wakes device, fully powered after 1 us
// [R10] while waking, frame rise before edge ten returns device to power-down
// [R11] on wake the sampler returns to track at first clock edge of frame
// [R12] one dummy cycle suffices up to 18 MHz; quiet interval still applies
// [R13] short dummy ok: after 1 us raise frame past edge ten, then quiet, convert
// [R14] after supply the mode is unknown; run a dummy cycle first
// [R15] no 1 us wait before mode dummy; allow acquisition before valid conversion
// [R16] after supply the sampler already tracks
// [R17] frame fall holds sample, starts conversion, enables output driver
// [R18] stream is four zeros then twelve bits, msb first, straight binary
// [R19] output released at sixteenth falling edge
// [R20] device counts falling edges from frame fall and decides mode at frame rise
// [R21] device keeps one power bit, updated at frame rise or frame completion
`ifndef APM_DEFINES_SVH
`define APM_DEFINES_SVH
`define APM_CLK_MHZ       20
`define APM_SCLK_HALF     5
`define APM_FULL_EDGES    16
`define APM_NORMAL_EDGES  10
`define APM_PDOWN_EDGES   4
`define APM_LEAD_ZEROS    4
`define APM_RES_BITS      12
`define APM_QUIET_NS      60
`define APM_QUIET_CYC     ((`APM_QUIET_NS * `APM_CLK_MHZ + 999) / 1000)
`define APM_PWRUP_NS      1000
`define APM_PWRUP_CYC     ((`APM_PWRUP_NS * `APM_CLK_MHZ + 999) / 1000)
`endif

/* File: hw/apm_pkg.sv */
// types for the converter power-mode host controller
package apm_pkg;
  typedef enum logic [2:0] {
    APM_IDLE  = 3'b000,
    APM_FALL  = 3'b001,
    APM_LOW   = 3'b010,
    APM_HIGH  = 3'b011,
    APM_RISE  = 3'b100,
    APM_QUIET = 3'b101
  } apm_state_e;
  typedef enum logic [1:0] {
    APM_OP_CONVERT = 2'b00,
    APM_OP_PDOWN   = 2'b01,
    APM_OP_WAKE    = 2'b10
  } apm_op_e;
endpackage

/* File: hw/apm_shift_if.sv */
// shift path carrier between frame sequencer and result capture
`timescale 1ns/10ps
interface apm_shift_if;
  logic        clear;
  logic        sample;
  logic [15:0] word;
  modport seq (output clear, output sample, input word);
  modport cap (input clear, input sample, output word);
endinterface

/* File: hw/apm_capture.sv */
// result capture shift register with pin synchroniser
`timescale 1ns/10ps
`include "apm_defines.svh"
module apm_capture (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // serial result pin
  input wire logic serial_result_out,
  // sequencer side
  apm_shift_if.cap sh
);
  import apm_pkg::*;
  typedef struct packed {
    logic        s1;
    logic        s2;
    logic [15:0] word;
  } apm_cap_s;
  apm_cap_s st_r;
  apm_cap_s st_nxt;
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = serial_result_out;
    st_nxt.s2 = st_r.s1;
    if (sh.clear) begin
      st_nxt.word = 16'h0000;
    end else if (sh.sample) begin
      st_nxt.word = {st_r.word[14:0], st_r.s2}; // R18
    end
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign sh.word = st_r.word;
endmodule

/* File: hw/apm_host.sv */
// host sequencer: frames, serial clock and power-mode control for the converter
`timescale 1ns/10ps
`include "apm_defines.svh"
module apm_host #(
  parameter int SCLK_HALF = `APM_SCLK_HALF,
  parameter int QUIET_CYC = `APM_QUIET_CYC,
  parameter int PWRUP_CYC = `APM_PWRUP_CYC
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             srst,
  // command
  input  wire logic             cmd_valid,
  input  wire apm_pkg::apm_op_e cmd_op,
  output logic                  cmd_ready,
  // result
  output logic                  res_valid,
  output logic [11:0]           res_data,
  output logic                  dev_powered,
  // converter pins
  output logic                  frame_n,
  output logic                  sclk,
  input  wire logic             serial_result_out
);
  import apm_pkg::*;

  // ==================================================
  // state
  typedef struct packed {
    apm_state_e  st;
    apm_op_e     op;
    logic [4:0]  edges;
    logic [4:0]  target;
    logic [7:0]  div;
    logic [7:0]  quiet;
    logic [7:0]  wake;
    logic        frame_n;
    logic        sclk;
    logic        ready;
    logic        rvalid;
    logic [11:0] rdata;
    logic        powered;
    logic        known;
    logic        clr;
    logic        smp;
  } apm_host_s;
  apm_host_s st_r;
  apm_host_s st_nxt;

  apm_shift_if sh ();

  apm_capture u_cap (
    .clock             (clock),
    .srst              (srst),
    .serial_result_out (serial_result_out),
    .sh                (sh)
  );

  assign sh.clear  = st_r.clr;
  assign sh.sample = st_r.smp;

  // ==================================================
  // sequencer
  always_comb begin
    st_nxt        = st_r;
    st_nxt.rvalid = 1'b0;
    st_nxt.clr    = 1'b0;
    st_nxt.smp    = 1'b0;
    if (st_r.wake != 8'h00 && st_r.frame_n == 1'b0) begin
      st_nxt.wake = st_r.wake - 8'h01;
    end
    unique case (st_r.st)
      APM_IDLE: begin
        st_nxt.frame_n = 1'b1; // R04
        st_nxt.sclk    = 1'b1;
        if (cmd_valid && st_r.ready) begin
          st_nxt.ready = 1'b0;
          st_nxt.op    = cmd_op;
          st_nxt.edges = 5'h00;
          st_nxt.div   = 8'h00;
          st_nxt.clr   = 1'b1;
          unique case (cmd_op)
            APM_OP_PDOWN: st_nxt.target = 5'(`APM_PDOWN_EDGES); // R06
            APM_OP_WAKE:  st_nxt.target = 5'(`APM_NORMAL_EDGES); // R09 R13
            default:      st_nxt.target = 5'(`APM_FULL_EDGES); // R03
          endcase
          if (cmd_op == APM_OP_WAKE) begin
            st_nxt.wake = 8'(PWRUP_CYC); // R09
          end
          st_nxt.frame_n = 1'b0; // R17
          st_nxt.st      = APM_FALL;
        end
      end
      APM_FALL: begin
        // first bit appears at frame fall: sample it, clock stays high
        st_nxt.div = st_r.div + 8'h01;
        if (st_r.div == 8'(SCLK_HALF - 1)) begin
          st_nxt.div  = 8'h00;
          st_nxt.smp  = 1'b1; // R18
          st_nxt.st   = APM_HIGH; // R20
        end
      end
      APM_LOW: begin
        st_nxt.div = st_r.div + 8'h01;
        if (st_r.div == 8'(SCLK_HALF - 1)) begin
          st_nxt.div  = 8'h00;
          st_nxt.sclk = 1'b1;
          st_nxt.st   = APM_HIGH;
          if (st_r.op == APM_OP_CONVERT && st_r.edges < 5'(`APM_FULL_EDGES)) begin
            st_nxt.smp = 1'b1; // R18
          end
        end
      end
      APM_HIGH: begin
        st_nxt.div = st_r.div + 8'h01;
        if (st_r.div == 8'(SCLK_HALF - 1)) begin
          st_nxt.div = 8'h00;
          // falling edge of the serial clock
          st_nxt.sclk  = 1'b0;
          st_nxt.edges = st_r.edges + 5'h01;
          st_nxt.st    = APM_LOW;
          if (st_r.edges + 5'h01 >= st_r.target) begin
            if (st_r.op != APM_OP_WAKE || st_r.wake <= 8'h01) begin
              st_nxt.st = APM_RISE; // R13
            end
          end
        end
      end
      APM_RISE: begin
        st_nxt.div = st_r.div + 8'h01;
        if (st_r.div == 8'(SCLK_HALF - 1)) begin
          st_nxt.div     = 8'h00;
          st_nxt.sclk    = 1'b1;
          st_nxt.frame_n = 1'b1;
          st_nxt.quiet   = 8'(QUIET_CYC);
          st_nxt.st      = APM_QUIET;
          unique case (st_r.op)
            APM_OP_PDOWN: st_nxt.powered = 1'b0; // R06 R07
            APM_OP_WAKE:  st_nxt.powered = 1'b1; // R09
            default: begin
              st_nxt.powered = st_r.powered;
              st_nxt.rvalid  = st_r.known && st_r.powered; // R14 R01
              st_nxt.rdata   = sh.word[11:0]; // R18
            end
          endcase
          if (st_r.op != APM_OP_CONVERT) begin
            st_nxt.known = 1'b1; // R14
          end
        end
      end
      APM_QUIET: begin
        st_nxt.frame_n = 1'b1;
        if (st_r.quiet != 8'h00) begin
          st_nxt.quiet = st_r.quiet - 8'h01; // R05 R12 R15
        end else begin
          st_nxt.ready = 1'b1;
          st_nxt.st    = APM_IDLE;
        end
      end
      default: st_nxt.st = APM_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st_r         <= '0;
      st_r.st      <= APM_IDLE;
      st_r.frame_n <= 1'b1;
      st_r.sclk    <= 1'b1;
      st_r.ready   <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cmd_ready   = st_r.ready;
  assign res_valid   = st_r.rvalid;
  assign res_data    = st_r.rdata;
  assign dev_powered = st_r.powered;
  assign frame_n     = st_r.frame_n;
  assign sclk        = st_r.sclk;
endmodule

/* File: tb/apm_host_chk.sv */
// assertion checker for the converter host controller
`timescale 1ns/10ps
module apm_host_chk #(
  parameter int PWRUP_CYC = 20
) (
  // clock and reset
  input wire logic             clock,
  input wire logic             srst,
  // command
  input wire logic             cmd_valid,
  input wire apm_pkg::apm_op_e cmd_op,
  input wire logic             cmd_ready,
  // status
  input wire logic             res_valid,
  input wire logic             dev_powered,
  // converter pins
  input wire logic             frame_n,
  input wire logic             sclk
);
  import apm_pkg::*;
  // ==========
  // frame edge and length counters
  logic [4:0] ecnt_r;
  logic [7:0] lcnt_r;
  apm_op_e    op_r;
  always_ff @(posedge clock) begin
    if (srst) begin
      ecnt_r <= 5'h00;
      lcnt_r <= 8'h00;
      op_r   <= APM_OP_CONVERT;
    end else begin
      if ($fell(frame_n)) ecnt_r <= 5'h00;
      else if (!frame_n && $fell(sclk)) ecnt_r <= ecnt_r + 5'h01;
      lcnt_r <= frame_n ? 8'h00 : lcnt_r + 8'h01;
      if (cmd_valid && cmd_ready) op_r <= cmd_op;
    end
  end
  // ==========
  // properties
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  take_opens_frame_a: assert property (cmd_valid && cmd_ready |=> !frame_n && !cmd_ready)
    else $error("frame did not open after command");
  idle_clk_high_a: assert property (frame_n |-> sclk)
    else $error("serial clock low outside frame");
  quiet_gap_a: assert property ($rose(frame_n) |-> frame_n[*3])
    else $error("frame reopened inside quiet gap");
  half_period_a: assert property ($fell(sclk) |-> (!sclk)[*5] ##1 sclk)
    else $error("serial clock low phase wrong");
  busy_in_frame_a: assert property (!frame_n |-> !cmd_ready)
    else $error("ready while frame open");
  edge_count_a: assert property ($rose(frame_n) |-> (ecnt_r == 5'h04 && op_r == APM_OP_PDOWN)
    || (ecnt_r == 5'h10 && op_r == APM_OP_CONVERT) || (ecnt_r >= 5'h0A && op_r == APM_OP_WAKE))
    else $error("frame closed at wrong edge count");
  pdown_clears_a: assert property ($rose(frame_n) && op_r == APM_OP_PDOWN |=> !dev_powered)
    else $error("power bit kept after power-down");
  wake_sets_a: assert property ($rose(frame_n) && op_r == APM_OP_WAKE
    |-> lcnt_r >= PWRUP_CYC ##1 dev_powered)
    else $error("wake frame short or power bit not set");
  result_known_a: assert property (res_valid |-> dev_powered && frame_n)
    else $error("result flagged in unknown mode");
  convert_keeps_a: assert property ($rose(frame_n) && op_r == APM_OP_CONVERT
    |=> $stable(dev_powered))
    else $error("convert changed power bit");
endmodule

/* File: tb/apm_dev_model.sv */
// behavioural converter at the host controller's far side
`timescale 1ns/10ps
module apm_dev_model #(
  parameter logic [11:0] VAL = 12'h5A3
) (
  // host pins
  input  wire logic frame_n,
  input  wire logic sclk,
  // result pin and power bit
  output logic      serial_result_out,
  output logic      powered
);
  logic [15:0] word;
  logic        drv = 1'b0;
  logic        bitv = 1'b0;
  int          cnt = 0;
  logic        tracking = 1'b1;
  logic        waking = 1'b0;
  // comes up powered down, a legal start
  initial powered = 1'b0;
  always @(negedge frame_n) begin
    cnt = 0;
    tracking = 1'b0;
    waking = !powered;
    word = {4'h0, powered ? VAL : 12'h000};
    drv = 1'b1;
    bitv = word[15];
  end
  always @(sclk) if (!frame_n && waking) begin
    tracking = 1'b1;
    waking = 1'b0;
  end
  always @(negedge sclk) if (!frame_n) begin
    cnt = cnt + 1;
    if (cnt >= 16) drv = 1'b0;
    else if (drv) bitv = word[15 - cnt];
  end
  always @(posedge frame_n) begin
    drv = 1'b0;
    if (cnt >= 2 && cnt < 10) powered = 1'b0;
    else if (cnt >= 10) powered = 1'b1;
  end
  // released pin shows the inverse of its last bit
  assign serial_result_out = drv ? bitv : ~bitv;
endmodule

/* File: tb/apm_host_bench.sv */
// self-checking bench for the converter host controller
`timescale 1ns/10ps
module apm_host_bench;
  import apm_pkg::*;
  localparam logic [11:0] VAL = 12'hA5C;
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic        cmd_valid = 1'b0;
  apm_op_e     cmd_op = APM_OP_CONVERT;
  logic        cmd_ready, res_valid, dev_powered, frame_n, sclk, sdo, pwr, rv;
  logic [11:0] res_data;
  int          n_errors = 0;
  int          compares = 0;
  int          edges = 0;
  apm_host u_apm_host (.clock(clock), .srst(srst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_ready(cmd_ready), .res_valid(res_valid), .res_data(res_data),
    .dev_powered(dev_powered), .frame_n(frame_n), .sclk(sclk), .serial_result_out(sdo));
  apm_dev_model #(.VAL(VAL)) u_apm_dev_model (.frame_n(frame_n), .sclk(sclk),
    .serial_result_out(sdo), .powered(pwr));
  initial begin
    forever #25 clock = ~clock;
  end
  always @(negedge frame_n) edges = 0;
  always @(negedge sclk) if (!frame_n) edges = edges + 1;
  // ==========
  // tasks
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk_bit(string nm, logic exp, logic got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s exp %b got %b", nm, exp, got);
    end
  endtask
  task automatic chk_word(string nm, logic [11:0] exp, logic [11:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic run(apm_op_e op);
    int i;
    i = 0;
    rv = 1'b0;
    cmd_valid <= 1'b1;
    cmd_op <= op;
    do begin
      @(posedge clock);
      i++;
    end while (cmd_ready !== 1'b1 && i < 50);
    cmd_valid <= 1'b0;
    if (i >= 50) begin
      n_errors++;
      close_out();
    end
    do begin
      @(posedge clock);
      i++;
      if (res_valid === 1'b1) rv = 1'b1;
    end while (cmd_ready !== 1'b1 && i < 2000);
    if (i >= 2000) begin
      n_errors++;
      close_out();
    end
  endtask
  task automatic t_reset();
    chk_bit("frame_n", 1'b1, frame_n);
    chk_bit("sclk", 1'b1, sclk);
    chk_bit("cmd_ready", 1'b1, cmd_ready);
    chk_bit("dev_powered", 1'b0, dev_powered);
    $display("test reset done");
  endtask
  task automatic t_unknown();
    run(APM_OP_CONVERT);
    chk_bit("res_valid", 1'b0, rv);
    chk_bit("edges16", 1'b1, edges == 16);
    $display("test unknown done");
  endtask
  task automatic t_wake();
    run(APM_OP_WAKE);
    chk_bit("edges_ge10", 1'b1, edges >= 10);
    chk_bit("dev_powered", 1'b1, dev_powered);
    chk_bit("model_power", 1'b1, pwr);
    $display("test wake done");
  endtask
  task automatic t_convert();
    run(APM_OP_CONVERT);
    chk_bit("res_valid", 1'b1, rv);
    chk_word("res_data", VAL, res_data);
    chk_bit("model_power", 1'b1, pwr);
    $display("test convert done");
  endtask
  task automatic t_pdown();
    run(APM_OP_PDOWN);
    chk_bit("edges_2to9", 1'b1, edges >= 2 && edges < 10);
    chk_bit("dev_powered", 1'b0, dev_powered);
    chk_bit("model_power", 1'b0, pwr);
    $display("test pdown done");
  endtask
  // ==========
  // main sequence
  initial begin
    repeat (10) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    t_reset();
    t_unknown();
    t_wake();
    t_convert();
    t_pdown();
    t_wake();
    t_convert();
    close_out();
  end
endmodule
bind apm_host apm_host_chk #(.PWRUP_CYC(PWRUP_CYC)) u_apm_host_chk (.clock(clock), .srst(srst),
  .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_ready(cmd_ready), .res_valid(res_valid),
  .dev_powered(dev_powered), .frame_n(frame_n), .sclk(sclk));
